// ---- design/t8c_compare_unit.sv ----
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
`include "t8c_regs.svh"
module t8c_compare_unit (
	input  wire logic             ref_clk,     // I/O clock, 100 MHz
	input  wire logic             rst_n,       // Async reset, low
	input  wire logic             timer_tick,  // Prescaler enable
	input  wire logic [2:0]       reg_addr,    // Register address
	input  wire t8c_pkg::t8c_byte_t reg_wdata, // Write data
	input  wire logic             reg_wr,      // Write strobe
	input  wire logic             reg_rd,      // Read strobe
	output t8c_pkg::t8c_byte_t    reg_rdata,   // Read data, next cycle
	input  wire logic             port_dir_a,  // Direction bit, pin A
	input  wire logic             port_dir_b,  // Direction bit, pin B
	input  wire logic             port_val_a,  // Port value, pin A
	input  wire logic             port_val_b,  // Port value, pin B
	output logic                  pin_a_out,   // Pin A level
	output logic                  pin_a_oe_n,  // Pin A enable, low
	output logic                  pin_b_out,   // Pin B level
	output logic                  pin_b_oe_n,  // Pin B enable, low
	output logic                  wave_out_a,  // Waveform A
	output logic                  wave_out_b,  // Waveform B
	output logic                  irq          // Match interrupt
);
	import t8c_pkg::*;

	function automatic t8c_kind_e kind_of(input logic [2:0] ws);
		case (ws)
			`T8C_WS_PHASE, `T8C_WS_PHASE_A: kind_of = T8C_PHASE;
			`T8C_WS_FAST, `T8C_WS_FAST_A:   kind_of = T8C_FAST;
			default:                        kind_of = T8C_NONPWM;
		endcase
	endfunction : kind_of

	function automatic logic ceiling_is_a(input logic [2:0] ws);
		ceiling_is_a = (ws == `T8C_WS_CTC) || (ws == `T8C_WS_PHASE_A) ||
			(ws == `T8C_WS_FAST_A);
	endfunction : ceiling_is_a

	logic [1:0] out_mode_a;
	logic [1:0] out_mode_b;
	logic [1:0] wsel_low;
	logic       wsel_high;
	t8c_byte_t  cmp_buf_a;
	t8c_byte_t  cmp_buf_b;
	t8c_byte_t  compare_value_a;
	t8c_byte_t  compare_value_b;
	t8c_byte_t  counter_value;
	logic       count_up;
	logic       block_match;
	logic [1:0] match_status;
	logic [1:0] match_mask;

	logic [1:0] next_out_mode_a;
	logic [1:0] next_out_mode_b;
	logic [1:0] next_wsel_low;
	logic       next_wsel_high;
	t8c_byte_t  next_cmp_buf_a;
	t8c_byte_t  next_cmp_buf_b;
	t8c_byte_t  next_compare_value_a;
	t8c_byte_t  next_compare_value_b;
	t8c_byte_t  next_counter_value;
	logic       next_count_up;
	logic       next_block_match;
	logic [1:0] next_match_status;
	logic [1:0] next_match_mask;
	t8c_byte_t  next_reg_rdata;

	logic [2:0] waveform_select;
	t8c_kind_e  kind;
	t8c_byte_t  ceiling;
	logic       at_top;
	logic       top_tick;
	logic       match_a;
	logic       match_b;
	logic       cnt_wr;
	logic       force_a;
	logic       force_b;
	logic [1:0] flag_clr;
	logic       con_a;
	logic       con_b;

	assign waveform_select = {wsel_high, wsel_low};
	assign kind = kind_of(waveform_select);
	assign ceiling = ceiling_is_a(waveform_select) ? compare_value_a
		: `T8C_MAX;
	assign at_top = (counter_value == ceiling);
	assign top_tick = timer_tick && at_top;
	assign cnt_wr = reg_wr && (reg_addr == `T8C_OFF_COUNT);
	// A counter write masks the compare on the next tick
	assign match_a = timer_tick && !block_match &&
		(counter_value == compare_value_a);
	assign match_b = timer_tick && !block_match &&
		(counter_value == compare_value_b);
	// Strobes only act outside PWM, otherwise they are dropped
	assign force_a = reg_wr && (reg_addr == `T8C_OFF_CTRL_B) &&
		reg_wdata[`T8C_FORCE_A] && (kind == T8C_NONPWM);
	assign force_b = reg_wr && (reg_addr == `T8C_OFF_CTRL_B) &&
		reg_wdata[`T8C_FORCE_B] && (kind == T8C_NONPWM);

	always_comb begin
		next_counter_value = counter_value;
		next_count_up = count_up;
		next_block_match = block_match;
		next_compare_value_a = compare_value_a;
		next_compare_value_b = compare_value_b;
		// Double buffered in PWM so a period never sees a half update
		if (kind == T8C_NONPWM) begin
			next_compare_value_a = cmp_buf_a;
			next_compare_value_b = cmp_buf_b;
		end else if (top_tick) begin
			next_compare_value_a = cmp_buf_a;
			next_compare_value_b = cmp_buf_b;
		end
		if (cnt_wr) begin
			next_counter_value = reg_wdata;
			next_block_match = 1'b1;
		end else if (timer_tick) begin
			next_block_match = 1'b0;
			if (kind == T8C_PHASE) begin
				if (count_up) begin
					if (at_top) begin
						next_count_up = 1'b0;
						next_counter_value = counter_value - 8'h01;
					end else begin
						next_counter_value = counter_value + 8'h01;
					end
				end else if (counter_value == `T8C_BOTTOM) begin
					next_count_up = 1'b1;
					next_counter_value = counter_value + 8'h01;
				end else begin
					next_counter_value = counter_value - 8'h01;
				end
			end else if (at_top) begin
				next_count_up = 1'b1;
				next_counter_value = `T8C_BOTTOM;
			end else begin
				next_count_up = 1'b1;
				next_counter_value = counter_value + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_value <= `T8C_RESET_BYTE;
			count_up <= 1'b1;
			block_match <= 1'b0;
			compare_value_a <= `T8C_RESET_BYTE;
			compare_value_b <= `T8C_RESET_BYTE;
		end else begin
			counter_value <= next_counter_value;
			count_up <= next_count_up;
			block_match <= next_block_match;
			compare_value_a <= next_compare_value_a;
			compare_value_b <= next_compare_value_b;
		end
	end

	always_comb begin
		next_out_mode_a = out_mode_a;
		next_out_mode_b = out_mode_b;
		next_wsel_low = wsel_low;
		next_wsel_high = wsel_high;
		next_cmp_buf_a = cmp_buf_a;
		next_cmp_buf_b = cmp_buf_b;
		next_match_mask = match_mask;
		flag_clr = 2'h0;
		if (reg_wr) begin
			case (reg_addr)
				`T8C_OFF_CTRL_A: begin
					next_out_mode_a = reg_wdata[`T8C_MODE_A];
					next_out_mode_b = reg_wdata[`T8C_MODE_B];
					next_wsel_low = reg_wdata[`T8C_WSEL_LOW];
				end
				`T8C_OFF_CTRL_B: next_wsel_high = reg_wdata[`T8C_WSEL_HIGH];
				`T8C_OFF_CMP_A:  next_cmp_buf_a = reg_wdata;
				`T8C_OFF_CMP_B:  next_cmp_buf_b = reg_wdata;
				`T8C_OFF_STATUS: flag_clr = reg_wdata[`T8C_FLAGS];
				`T8C_OFF_MASK:   next_match_mask = reg_wdata[`T8C_FLAGS];
				default: ;
			endcase
		end
		// Set beats a clear in the same cycle; forced hits never flag
		next_match_status = (match_status & ~flag_clr) |
			{match_b, match_a};
		next_reg_rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`T8C_OFF_CTRL_A: next_reg_rdata =
					{out_mode_a, out_mode_b, 2'b00, wsel_low};
				// Strobe bits always read back as zero
				`T8C_OFF_CTRL_B: next_reg_rdata =
					{4'h0, wsel_high, 3'h0};
				`T8C_OFF_COUNT:  next_reg_rdata = counter_value;
				`T8C_OFF_CMP_A:  next_reg_rdata = cmp_buf_a;
				`T8C_OFF_CMP_B:  next_reg_rdata = cmp_buf_b;
				`T8C_OFF_STATUS: next_reg_rdata = {6'h00, match_status};
				`T8C_OFF_MASK:   next_reg_rdata = {6'h00, match_mask};
				default:         next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_mode_a <= 2'h0;
			out_mode_b <= 2'h0;
			wsel_low <= 2'h0;
			wsel_high <= 1'b0;
			cmp_buf_a <= `T8C_RESET_BYTE;
			cmp_buf_b <= `T8C_RESET_BYTE;
			match_status <= 2'h0;
			match_mask <= 2'h0;
			reg_rdata <= `T8C_RESET_BYTE;
		end else begin
			out_mode_a <= next_out_mode_a;
			out_mode_b <= next_out_mode_b;
			wsel_low <= next_wsel_low;
			wsel_high <= next_wsel_high;
			cmp_buf_a <= next_cmp_buf_a;
			cmp_buf_b <= next_cmp_buf_b;
			match_status <= next_match_status;
			match_mask <= next_match_mask;
			reg_rdata <= next_reg_rdata;
		end
	end

	t8c_wave_chan #(
		.HAS_TOGGLE (1'b1)
	) u_chan_a (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.kind       (kind),
		.out_mode   (out_mode_a),
		.wsel_high  (wsel_high),
		.match      (match_a),
		.top_tick   (top_tick),
		.cmp_is_top (compare_value_a == ceiling),
		.count_up   (count_up),
		.force_hit  (force_a),
		.wave_out   (wave_out_a),
		.connected  (con_a)
	);

	// Channel B has no toggle in PWM; 01 there is reserved
	t8c_wave_chan #(
		.HAS_TOGGLE (1'b0)
	) u_chan_b (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.kind       (kind),
		.out_mode   (out_mode_b),
		.wsel_high  (wsel_high),
		.match      (match_b),
		.top_tick   (top_tick),
		.cmp_is_top (compare_value_b == ceiling),
		.count_up   (count_up),
		.force_hit  (force_b),
		.wave_out   (wave_out_b),
		.connected  (con_b)
	);

	// Takeover only picks the level; direction bit alone drives
	assign pin_a_out = con_a ? wave_out_a : port_val_a;
	assign pin_b_out = con_b ? wave_out_b : port_val_b;
	assign pin_a_oe_n = ~port_dir_a;
	assign pin_b_oe_n = ~port_dir_b;
	assign irq = |(match_status & match_mask);

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_flag_a_set: assert property (match_a |=> match_status[0])
		else $error("match flag A not raised");
	a_flag_b_set: assert property (match_b |=> match_status[1])
		else $error("match flag B not raised");
	a_ctc_clear_cnt: assert property (
		(waveform_select == `T8C_WS_CTC && match_a && !cnt_wr)
		|=> counter_value == `T8C_BOTTOM && match_status[0])
		else $error("clear-on-match did not clear counter");
	a_tick_hold_cnt: assert property (
		(!timer_tick && !cnt_wr) |=> $stable(counter_value))
		else $error("counter moved without tick");
	a_force_no_flag: assert property (
		(force_a && !match_a && !match_status[0]) |=> !match_status[0])
		else $error("force strobe raised a flag");
	a_strobe_read_zero: assert property (
		(reg_rd && reg_addr == `T8C_OFF_CTRL_B) |=> reg_rdata[7:6] == 2'b00)
		else $error("force strobe read back nonzero");
	a_write_blocks: assert property (
		cnt_wr |=> !match_a && !match_b)
		else $error("match not blocked after counter write");
	a_fast_b_reserved: assert property (
		(kind == T8C_FAST && out_mode_b == 2'b01) |-> !con_b)
		else $error("reserved fast PWM B mode took pin");
	a_pwm_a_gated: assert property (
		(kind != T8C_NONPWM && out_mode_a == 2'b01 && !wsel_high) |->
		pin_a_out == port_val_a)
		else $error("PWM A mode 01 took pin with select high 0");
endmodule : t8c_compare_unit

// ---- design/t8c_regs.svh ----
`ifndef T8C_REGS_SVH
`define T8C_REGS_SVH
// How it works
// - All logic runs on ref_clk; timer_tick only qualifies count and compare.
// - Both match flags set on every compare match in every mode.
// - Clear-on-match and fast PWM with ceiling A: match A flags and clears.
// - Nonzero mode field A hands the pin to wave output A, except PWM 01 with select high 0.
// - Nonzero mode field B hands the pin to wave output B, except 01 in PWM.
// - Non-PWM mode A: off, toggle, clear, set on match.
// - PWM mode A 01: off when select high is 0, else toggle.
// - Fast PWM A: 10 clear on match set at ceiling; 11 inverse.
// - Phase PWM A: 10 clear on up match, set on down; 11 inverse.
// - PWM A 10/11: compare equal to ceiling ignores match, acts at ceiling.
// - Non-PWM mode B: off, toggle, clear, set on match.
// - Fast PWM B: 01 reserved; 10 and 11 as for channel A.
// - Phase PWM B: 01 reserved; 10 and 11 as for channel A.
// - PWM B: compare equal to ceiling ignores match, acts at ceiling.
// - Select 0 normal, 1/5 phase, 2 clear-on-match, 3/7 fast; ceiling.
// - Non-PWM force strobe applies action only; no flag, reads zero.

`define T8C_OFF_CTRL_A  3'h0
`define T8C_OFF_CTRL_B  3'h1
`define T8C_OFF_COUNT   3'h2
`define T8C_OFF_CMP_A   3'h3
`define T8C_OFF_CMP_B   3'h4
`define T8C_OFF_STATUS  3'h5
`define T8C_OFF_MASK    3'h6

`define T8C_MODE_A      7:6
`define T8C_MODE_B      5:4
`define T8C_WSEL_LOW    1:0
`define T8C_FORCE_A     7
`define T8C_FORCE_B     6
`define T8C_WSEL_HIGH   3
`define T8C_FLAGS       1:0

`define T8C_RESET_BYTE  8'h00
`define T8C_BOTTOM      8'h00
`define T8C_MAX         8'hFF

`define T8C_WS_PHASE    3'h1
`define T8C_WS_CTC      3'h2
`define T8C_WS_FAST     3'h3
`define T8C_WS_PHASE_A  3'h5
`define T8C_WS_FAST_A   3'h7
`endif

// ---- design/t8c_pkg.sv ----
package t8c_pkg;
	typedef enum logic [1:0] {
		T8C_NONPWM = 2'h0,
		T8C_FAST   = 2'h1,
		T8C_PHASE  = 2'h3
	} t8c_kind_e;

	typedef logic [7:0] t8c_byte_t;
endpackage : t8c_pkg

// ---- design/t8c_wave_chan.sv ----
`timescale 1ns/1ns
module t8c_wave_chan #(
	parameter bit HAS_TOGGLE = 1'b1 // PWM toggle option present
) (
	input  wire logic             ref_clk,    // I/O clock
	input  wire logic             rst_n,      // Async reset, low
	input  wire t8c_pkg::t8c_kind_e kind,     // Waveform family
	input  wire logic [1:0]       out_mode,   // Output mode field
	input  wire logic             wsel_high,  // Upper select bit
	input  wire logic             match,      // Qualified match
	input  wire logic             top_tick,   // Tick at ceiling
	input  wire logic             cmp_is_top, // Compare equals ceiling
	input  wire logic             count_up,   // Count direction
	input  wire logic             force_hit,  // Forced match
	output logic                  wave_out,   // Waveform register
	output logic                  connected   // Pin taken over
);
	import t8c_pkg::*;

	logic next_wave;
	logic pwm_toggle;

	always_comb begin
		pwm_toggle = HAS_TOGGLE && wsel_high && (out_mode == 2'b01);
		next_wave = wave_out;
		case (kind)
			T8C_NONPWM: begin
				if (match || force_hit) begin
					case (out_mode)
						2'b01:   next_wave = ~wave_out;
						2'b10:   next_wave = 1'b0;
						2'b11:   next_wave = 1'b1;
						default: next_wave = wave_out;
					endcase
				end
			end
			T8C_FAST: begin
				if (out_mode[1]) begin
					// Ceiling action wins, so equal compare gives a flat line
					if (top_tick)
						next_wave = ~out_mode[0];
					else if (match && !cmp_is_top)
						next_wave = out_mode[0];
				end else if (pwm_toggle && match) begin
					next_wave = ~wave_out;
				end
			end
			T8C_PHASE: begin
				if (out_mode[1]) begin
					if (cmp_is_top) begin
						if (top_tick)
							next_wave = ~out_mode[0];
					end else if (match) begin
						next_wave = count_up ? out_mode[0] : ~out_mode[0];
					end
				end else if (pwm_toggle && match) begin
					next_wave = ~wave_out;
				end
			end
			default: next_wave = wave_out;
		endcase
		// Reserved or gated 01 in PWM leaves the pin to the port
		connected = (out_mode != 2'b00) &&
			!((kind != T8C_NONPWM) && (out_mode == 2'b01) && !pwm_toggle);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			wave_out <= 1'b0;
		else
			wave_out <= next_wave;
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_nonpwm_set_out: assert property (
		(kind == T8C_NONPWM && match && out_mode == 2'b11) |=> wave_out)
		else $error("non-PWM set on match missed");
	a_fast_ceiling_set: assert property (
		(kind == T8C_FAST && top_tick && out_mode == 2'b10) |=> wave_out)
		else $error("fast PWM set at ceiling missed");
	a_phase_up_clear: assert property (
		(kind == T8C_PHASE && match && count_up && !cmp_is_top &&
		out_mode == 2'b10) |=> !wave_out)
		else $error("phase PWM clear on up match missed");
	a_mode_off_disc: assert property (
		(out_mode == 2'b00) |-> !connected ##1 $stable(wave_out))
		else $error("output connected with mode zero");
endmodule : t8c_wave_chan

// ---- verification/t8c_pin_load.sv ----
`timescale 1ns/1ns
module t8c_pin_load (
	input  wire logic ref_clk,  // I/O clock
	input  wire logic rst_n,    // Async reset, low
	input  wire logic pin_out,  // Level offered at pin
	input  wire logic pin_oe_n, // Driver enable, low
	output logic      level     // Level the load sees
);
	logic last;

	// Undriven pin floats; show inverse so a stale value cannot pass
	assign level = pin_oe_n ? ~last : pin_out;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			last <= 1'b0;
		else if (!pin_oe_n)
			last <= pin_out;
	end
endmodule : t8c_pin_load

// ---- verification/t8c_compare_unit_test.sv ----
`timescale 1ns/1ns
module t8c_compare_unit_test;
	import t8c_pkg::*;
	logic      ref_clk, rst_n, timer_tick, reg_wr, reg_rd;
	logic [2:0] reg_addr;
	t8c_byte_t reg_wdata, reg_rdata;
	logic      port_dir_a, port_dir_b, port_val_a, port_val_b;
	logic      pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n;
	logic      wave_out_a, wave_out_b, irq, seen_a, seen_b;
	int        miscompares, num_checks;

	t8c_compare_unit i_t8c_compare_unit (.ref_clk(ref_clk), .rst_n(rst_n),
		.timer_tick(timer_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_dir_a(port_dir_a), .port_dir_b(port_dir_b),
		.port_val_a(port_val_a), .port_val_b(port_val_b),
		.pin_a_out(pin_a_out), .pin_a_oe_n(pin_a_oe_n),
		.pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n),
		.wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .irq(irq));
	t8c_pin_load i_t8c_pin_load_a (.ref_clk(ref_clk), .rst_n(rst_n),
		.pin_out(pin_a_out), .pin_oe_n(pin_a_oe_n), .level(seen_a));
	t8c_pin_load i_t8c_pin_load_b (.ref_clk(ref_clk), .rst_n(rst_n),
		.pin_out(pin_b_out), .pin_oe_n(pin_b_oe_n), .level(seen_b));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input string what, input logic [2:0] a,
		input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(what, reg_rdata, exp);
	endtask : rd

	task automatic tick(input int n);
		@(posedge ref_clk);
		timer_tick <= 1'b1;
		repeat (n) @(posedge ref_clk);
		timer_tick <= 1'b0;
		#1;
	endtask : tick

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end

	initial begin
		logic exp_a;
		logic exp_b;
		rst_n = 1'b0; timer_tick = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
		reg_addr = 3'h0; reg_wdata = 8'h00; port_dir_a = 1'b1;
		port_dir_b = 1'b1; port_val_a = 1'b1; port_val_b = 1'b0;
		miscompares = 0; num_checks = 0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd("ctrl_a", 3'h0, 8'h00);
		rd("status", 3'h5, 8'h00);
		chk("irq", irq, 1'b0);
		chk("pin_a", seen_a, 1'b1);
		chk("pin_b", seen_b, 1'b0);
		chk("oe_a", pin_a_oe_n, 1'b0);
		chk("oe_b", pin_b_oe_n, 1'b0);
		wr(3'h7, 8'h5A);
		rd("unmapped", 3'h7, 8'h00);
		$display("test reset done");

		wr(3'h3, 8'h03); wr(3'h4, 8'h02); wr(3'h0, 8'h72); wr(3'h2, 8'h00);
		tick(4);
		chk("wave_a", seen_a, 1'b1);
		chk("wave_b", seen_b, 1'b1);
		rd("status", 3'h5, 8'h03);
		rd("count", 3'h2, 8'h00);
		repeat (10) @(posedge ref_clk);
		rd("count idle", 3'h2, 8'h00);
		wr(3'h6, 8'h01);
		#1 chk("irq on", irq, 1'b1);
		wr(3'h5, 8'h01);
		rd("status clr", 3'h5, 8'h02);
		chk("irq off", irq, 1'b0);
		wr(3'h6, 8'h02);
		#1 chk("irq b", irq, 1'b1);
		tick(4);
		chk("toggle a", seen_a, 1'b0);
		$display("test clear on match done");

		wr(3'h5, 8'h03);
		exp_a = 1'b0;
		// B was left high by its set-on-match runs above
		exp_b = 1'b1;
		for (int m = 1; m < 5; m++) begin
			wr(3'h0, {2'(m), 2'(m), 4'h0});
			wr(3'h1, 8'hC0);
			@(posedge ref_clk);
			#1;
			exp_a = (m % 4 == 1) ? ~exp_a : (m == 2 ? 1'b0 : 1'b1);
			exp_b = (m % 4 == 1) ? ~exp_b : (m == 2 ? 1'b0 : 1'b1);
			chk("force a", wave_out_a, exp_a);
			chk("force b", wave_out_b, exp_b);
		end
		rd("no flag", 3'h5, 8'h00);
		rd("strobe", 3'h1, 8'h00);
		$display("test force done");

		wr(3'h3, 8'h02); wr(3'h4, 8'h04); wr(3'h2, 8'hFD); wr(3'h0, 8'hB3);
		tick(3);
		chk("fast a top", seen_a, 1'b1);
		chk("fast b top", seen_b, 1'b0);
		tick(3);
		chk("fast a hit", seen_a, 1'b0);
		tick(2);
		chk("fast b hit", seen_b, 1'b1);
		wr(3'h0, 8'h53);
		#1 chk("a off", seen_a, 1'b1);
		chk("b reserved", seen_b, 1'b0);
		wr(3'h1, 8'h08);
		#1 chk("a on", seen_a, 1'b0);
		$display("test fast done");

		wr(3'h1, 8'h00); wr(3'h0, 8'h00);
		wr(3'h3, 8'h40); wr(3'h4, 8'h41); wr(3'h2, 8'h00); wr(3'h0, 8'hE1);
		tick(100);
		chk("phase a up", seen_a, 1'b1);
		chk("phase b up", seen_b, 1'b0);
		tick(380);
		chk("phase a dn", seen_a, 1'b0);
		chk("phase b dn", seen_b, 1'b1);
		// Dropping the direction bit must release the driver
		port_dir_a <= 1'b0;
		@(posedge ref_clk);
		#1 chk("oe_a off", pin_a_oe_n, 1'b1);
		$display("test phase done");
		print_verdict();
	end
endmodule : t8c_compare_unit_test
